// *** hdl/bcd_pkg.sv ***
// Shared constants, word layout and helpers for the command decoder pair
package bcd_pkg;
   // ------------------------------------------------------------
   // Command word layout
   // ------------------------------------------------------------
   localparam int         WORD_W         = 16;
   localparam int         BYTE_W         = 8;
   localparam int         PAR_HI         = 15;
   localparam int         PAR_LO         = 14;
   localparam int         DEST_HI        = 13;
   localparam int         DEST_LO        = 10;
   localparam int         LEN_HI         = 9;
   localparam int         LEN_LO         = 7;
   localparam int         FUNC_HI        = 6;
   localparam int         DEST_W         = 4;
   localparam int         NEED_W         = 4;
   localparam logic [3:0] LOADER_DEST    = 4'h2;
   localparam logic [3:0] SEQ_LOAD_DEST  = 4'hE;
   localparam int         BYTES_PER_WORD = 2;
   localparam int         CNT_W          = 16;
   localparam int         PROC_W         = 2;
   // Processor per destination, two bits each, destination 0 lowest
   localparam logic [31:0] DEST_PROC_MAP = 32'hAA955000;

   // ------------------------------------------------------------
   // Timing and sizes
   // ------------------------------------------------------------
   localparam longint RTI_NS         = 64'd125000000;
   localparam longint CLK_MHZ        = 64'd200;
   localparam int     RTI_CYC        = int'(RTI_NS * CLK_MHZ / 64'd1000);
   localparam int     CMD_FIFO_DEPTH = 8;
   localparam int     MAX_CMD_WORDS  = 8;
   localparam int     TLM_W          = 32;
   localparam int     TLM_BLK_WORDS  = 8;

   // ------------------------------------------------------------
   // Field helpers
   // ------------------------------------------------------------
   // Expected parity: odd over destination and length, even over function
   function automatic logic [1:0] bcd_par(input logic [WORD_W-1:0] w);
      return {~^w[DEST_HI:LEN_LO], ^w[FUNC_HI:0]};
   endfunction : bcd_par

   function automatic logic [DEST_W-1:0] bcd_dest(input logic [WORD_W-1:0] w);
      return w[DEST_HI:DEST_LO];
   endfunction : bcd_dest

   function automatic logic [NEED_W-1:0] bcd_len(input logic [WORD_W-1:0] w);
      return {1'b0, w[LEN_HI:LEN_LO]} + 4'h1;
   endfunction : bcd_len

   function automatic logic [PROC_W-1:0] bcd_proc(input logic [DEST_W-1:0] d);
      return DEST_PROC_MAP[{d, 1'b0} +: PROC_W];
   endfunction : bcd_proc
endpackage : bcd_pkg

// *** hdl/bcd_link_if.sv ***
// Link between the spacecraft bus end and the command decoder end
`timescale 1ns/100ps
interface bcd_link_if;
   import bcd_pkg::*;
   logic [WORD_W-1:0] cmd_word;
   logic              cmd_valid;
   logic              cmd_last;
   logic              cmd_ext;
   logic              cmd_ready;
   logic              rti_pulse;
   logic [TLM_W-1:0]  tlm_word;
   logic              tlm_valid;
   logic              tlm_last;
   logic              tlm_ready;

   modport dev (
      input  cmd_word, cmd_valid, cmd_last, cmd_ext, tlm_ready,
      output cmd_ready, rti_pulse, tlm_word, tlm_valid, tlm_last
   );
   modport host (
      output cmd_word, cmd_valid, cmd_last, cmd_ext, tlm_ready,
      input  cmd_ready, rti_pulse, tlm_word, tlm_valid, tlm_last
   );
endinterface : bcd_link_if

// *** hdl/bcd_fifo.sv ***
// Command word FIFO with flush, valid and ready on both sides
`timescale 1ns/100ps
module bcd_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 8
) (
   input  logic                     clock,
   input  logic                     rst_n,
   input  logic                     ce,
   input  logic                     flush,
   input  logic [W-1:0]             in_data,
   input  logic                     in_valid,
   output logic                     in_ready,
   output logic [W-1:0]             out_data,
   output logic                     out_valid,
   input  logic                     out_ready,
   output logic [$clog2(DEPTH):0]   count
);
   import bcd_pkg::*;
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("bcd_fifo depth must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
   } bcd_fifo_st_t;

   bcd_fifo_st_t st_ff;
   bcd_fifo_st_t nxt_st;
   logic         push;
   logic         pop;

   // Flags straight from the held count
   assign in_ready  = (st_ff.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_ff.cnt != '0);
   assign out_data  = st_ff.mem[st_ff.rp];
   assign count     = st_ff.cnt;

   // Flush beats a push in the same cycle so a dropped command leaves nothing
   always_comb begin
      nxt_st = st_ff;
      push   = in_valid && in_ready;
      pop    = out_valid && out_ready;
      if (flush) begin
         nxt_st.wp  = '0;
         nxt_st.rp  = '0;
         nxt_st.cnt = '0;
      end else begin
         if (push) begin
            nxt_st.mem[st_ff.wp] = in_data;
            nxt_st.wp            = st_ff.wp + 1'b1;
         end
         if (pop) begin
            nxt_st.rp = st_ff.rp + 1'b1;
         end
         nxt_st.cnt = st_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end
endmodule : bcd_fifo

// *** hdl/bcd_decoder_end.sv ***
// First-level command decoder and telemetry packer, instrument end
// Notes on behaviour
// - Four destination bits pick one of sixteen
// - Length field splits buffer into commands
// - Check both first-word parity bits
// - Parity failure drops rest of buffer
// - Function bits forwarded untouched
// - Reversed parity loader commands rejected
// - Sequence load arrives alone per interval
// - Forward commands over channel to processor
// - Byte counter counts spacecraft commands only
// - Telemetry released only in full blocks
// - High rate data bypasses block packing
// - Channel idle while controller is written
// - Channel serves one target at once
// - Interval pulse every eighth second
`timescale 1ns/100ps
module bcd_decoder_end #(
   parameter int RTI_CYCLES = bcd_pkg::RTI_CYC,
   parameter int BLK        = bcd_pkg::TLM_BLK_WORDS,
   parameter int DEPTH      = bcd_pkg::CMD_FIFO_DEPTH
) (
   input  logic                        clock,
   input  logic                        rst_n,
   input  logic                        ce,
   bcd_link_if.dev                     link,
   output logic [bcd_pkg::BYTE_W-1:0]  ipc_data,
   output logic                        ipc_valid,
   output logic                        ipc_first,
   output logic [bcd_pkg::PROC_W-1:0]  ipc_proc,
   input  logic                        ipc_ready,
   input  logic [bcd_pkg::TLM_W-1:0]   tlm_in_word,
   input  logic                        tlm_in_valid,
   input  logic                        tlm_in_hrs,
   output logic                        tlm_in_ready,
   input  logic                        bpc_write,
   output logic                        dma_active,
   output logic [bcd_pkg::CNT_W-1:0]   cmd_byte_count,
   output logic                        parity_drop,
   output logic                        length_drop
);
   import bcd_pkg::*;
   localparam int RW = $clog2(RTI_CYCLES);
   localparam int BW = $clog2(BLK);
   localparam int FW = $clog2(DEPTH) + 1;

   if (RTI_CYCLES < 2 || BLK < 2 || DEPTH < MAX_CMD_WORDS) begin : g_bad_par
      $error("bcd_decoder_end parameters out of range");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_BODY, ST_SEQ, ST_DROP, ST_FWD} bcd_dec_t;
   typedef enum logic [1:0] {PH_NONE, PH_HI, PH_LO} bcd_ph_t;

   typedef struct packed {
      bcd_dec_t                 st;
      logic [NEED_W-1:0]        need;
      logic [PROC_W-1:0]        proc;
      logic                     first;
      logic                     crdy;
      bcd_ph_t                  ph;
      logic [WORD_W-1:0]        sw;
      logic                     iv;
      logic [BYTE_W-1:0]        id;
      logic                     ifirst;
      logic [PROC_W-1:0]        iproc;
      logic                     dma;
      logic [CNT_W-1:0]         bytes;
      logic                     pdrop;
      logic                     ldrop;
      logic [RW-1:0]            rti_cnt;
      logic                     real_time_interval;
      logic [BLK-1:0][TLM_W-1:0] blk;
      logic [BW-1:0]            wcnt;
      logic                     rel;
      logic                     tv;
      logic [TLM_W-1:0]         tw;
      logic                     tl;
      logic                     trdy;
   } bcd_dev_st_t;

   bcd_dev_st_t       st_ff;
   bcd_dev_st_t       nxt_st;
   logic              acc;
   logic [WORD_W-1:0] w;
   logic              push;
   logic              pop;
   logic              flush;
   logic              drain;
   logic              emit;
   logic              tslot;
   logic              tacc;
   logic [FW-1:0]     cnt_nxt;
   logic              f_ready;
   logic [WORD_W-1:0] f_data;
   logic              f_valid;
   logic [FW-1:0]     f_cnt;

   // ------------------------------------------------------------
   // Command buffer
   // ------------------------------------------------------------
   bcd_fifo #(
      .W     (WORD_W),
      .DEPTH (DEPTH)
   ) u_cmd_fifo (
      .clock     (clock),
      .rst_n     (rst_n),
      .ce        (ce),
      .flush     (flush),
      .in_data   (w),
      .in_valid  (push),
      .in_ready  (f_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (pop),
      .count     (f_cnt)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_st       = st_ff;
      w            = link.cmd_word;
      acc          = link.cmd_valid && st_ff.crdy;
      push         = 1'b0;
      flush        = 1'b0;
      pop          = 1'b0;
      nxt_st.pdrop = 1'b0;
      nxt_st.ldrop = 1'b0;

      nxt_st.real_time_interval = 1'b0;
      if (st_ff.rti_cnt == RW'(RTI_CYCLES - 1)) begin
         nxt_st.rti_cnt = '0;
         nxt_st.real_time_interval     = 1'b1;
      end else begin
         nxt_st.rti_cnt = st_ff.rti_cnt + 1'b1;
      end

      if (acc && link.cmd_ext) begin
         nxt_st.bytes = st_ff.bytes + CNT_W'(BYTES_PER_WORD);
      end

      // Command splitting; the pushed word keeps its function bits
      if (acc) begin
         unique case (st_ff.st)
            ST_IDLE: begin
               if (w[PAR_HI:PAR_LO] != bcd_par(w)) begin
                  nxt_st.pdrop = 1'b1;
                  if (!link.cmd_last) begin
                     nxt_st.st = ST_DROP;
                  end
               end else if (bcd_dest(w) == SEQ_LOAD_DEST) begin
                  push         = 1'b1;
                  nxt_st.first = 1'b1;
                  nxt_st.proc  = bcd_proc(bcd_dest(w));
                  nxt_st.st    = link.cmd_last ? ST_FWD : ST_SEQ;
               end else if (link.cmd_last && bcd_len(w) != 4'h1) begin
                  nxt_st.ldrop = 1'b1;
               end else begin
                  push         = 1'b1;
                  nxt_st.first = 1'b1;
                  nxt_st.proc  = bcd_proc(bcd_dest(w));
                  nxt_st.need  = bcd_len(w) - 4'h1;
                  nxt_st.st    = (bcd_len(w) == 4'h1) ? ST_FWD : ST_BODY;
               end
            end
            ST_BODY: begin
               push = 1'b1;
               if (st_ff.need == 4'h1) begin
                  nxt_st.st = ST_FWD;
               end else if (link.cmd_last) begin
                  flush        = 1'b1;
                  nxt_st.ldrop = 1'b1;
                  nxt_st.st    = ST_IDLE;
               end else begin
                  nxt_st.need = st_ff.need - 4'h1;
               end
            end
            ST_SEQ: begin
               push = 1'b1;
               if (link.cmd_last) begin
                  nxt_st.st = ST_FWD;
               end
            end
            ST_DROP: begin
               if (link.cmd_last) begin
                  nxt_st.st = ST_IDLE;
               end
            end
            ST_FWD: begin
               nxt_st.st = st_ff.st;
            end
         endcase
      end

      // hold channel while controller is written
      drain = (st_ff.st == ST_FWD || st_ff.st == ST_SEQ) && !bpc_write;
      emit  = (!st_ff.iv || ipc_ready) && !bpc_write;
      if (st_ff.iv && ipc_ready) begin
         nxt_st.iv = 1'b0;
      end

      // one target per command, high byte first
      unique case (st_ff.ph)
         PH_NONE: begin
            if (f_valid && drain) begin
               pop       = 1'b1;
               nxt_st.sw = f_data;
               nxt_st.ph = PH_HI;
            end
         end
         PH_HI: begin
            if (emit) begin
               nxt_st.iv     = 1'b1;
               nxt_st.id     = st_ff.sw[WORD_W-1 -: BYTE_W];
               nxt_st.ifirst = st_ff.first;
               nxt_st.iproc  = st_ff.proc;
               nxt_st.first  = 1'b0;
               nxt_st.ph     = PH_LO;
            end
         end
         PH_LO: begin
            if (emit) begin
               nxt_st.iv     = 1'b1;
               nxt_st.id     = st_ff.sw[BYTE_W-1:0];
               nxt_st.ifirst = 1'b0;
               nxt_st.ph     = PH_NONE;
            end
         end
         default: nxt_st.ph = PH_NONE;
      endcase

      // Command done once its last byte has left
      if (st_ff.st == ST_FWD && f_cnt == '0 && st_ff.ph == PH_NONE && !st_ff.iv) begin
         nxt_st.st = ST_IDLE;
      end

      // Registered ready: predict room for one more word next cycle
      cnt_nxt     = flush ? '0 : (f_cnt + FW'(push) - FW'(pop));
      nxt_st.crdy = (nxt_st.st != ST_FWD)
                    && (nxt_st.st == ST_DROP || cnt_nxt < FW'(DEPTH));
      nxt_st.dma  = (nxt_st.st == ST_FWD || nxt_st.st == ST_SEQ) && !bpc_write;

      // Telemetry output slot
      tslot = !st_ff.tv || link.tlm_ready;
      tacc  = tlm_in_valid && st_ff.trdy;
      if (tslot) begin
         nxt_st.tv = 1'b0;
      end
      if (st_ff.rel) begin
         if (tslot) begin
            nxt_st.tv = 1'b1;
            nxt_st.tw = st_ff.blk[st_ff.wcnt];
            nxt_st.tl = (st_ff.wcnt == BW'(BLK - 1));
            if (st_ff.wcnt == BW'(BLK - 1)) begin
               nxt_st.rel  = 1'b0;
               nxt_st.wcnt = '0;
            end else begin
               nxt_st.wcnt = st_ff.wcnt + 1'b1;
            end
         end
      end else if (tacc) begin
         if (tlm_in_hrs) begin
            nxt_st.tv = 1'b1;
            nxt_st.tw = tlm_in_word;
            nxt_st.tl = 1'b1;
         end else begin
            nxt_st.blk[st_ff.wcnt] = tlm_in_word;
            if (st_ff.wcnt == BW'(BLK - 1)) begin
               nxt_st.rel  = 1'b1;
               nxt_st.wcnt = '0;
            end else begin
               nxt_st.wcnt = st_ff.wcnt + 1'b1;
            end
         end
      end
      // Only take input with the output slot empty, so no word is overwritten
      nxt_st.trdy = !nxt_st.rel && !nxt_st.tv;
   end

   // ------------------------------------------------------------
   // Registers and outputs
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign link.cmd_ready = st_ff.crdy;
   assign link.rti_pulse = st_ff.real_time_interval;
   assign link.tlm_word  = st_ff.tw;
   assign link.tlm_valid = st_ff.tv;
   assign link.tlm_last  = st_ff.tl;
   assign ipc_data       = st_ff.id;
   assign ipc_valid      = st_ff.iv;
   assign ipc_first      = st_ff.ifirst;
   assign ipc_proc       = st_ff.iproc;
   assign tlm_in_ready   = st_ff.trdy;
   assign dma_active     = st_ff.dma;
   assign cmd_byte_count = st_ff.bytes;
   assign parity_drop    = st_ff.pdrop;
   assign length_drop    = st_ff.ldrop;
endmodule : bcd_decoder_end

// *** hdl/bcd_bus_end.sv ***
// Spacecraft bus controller end: paces buffers and accepts telemetry
`timescale 1ns/100ps
module bcd_bus_end (
   input  logic                        clock,
   input  logic                        rst_n,
   input  logic                        ce,
   bcd_link_if.host                    link,
   input  logic [bcd_pkg::WORD_W-1:0]  src_word,
   input  logic                        src_valid,
   input  logic                        src_last,
   input  logic                        src_raw,
   input  logic                        src_ext,
   output logic                        src_ready,
   output logic [bcd_pkg::TLM_W-1:0]   snk_word,
   output logic                        snk_valid,
   output logic                        snk_last,
   input  logic                        snk_ready
);
   import bcd_pkg::*;

   typedef enum logic {HS_WAIT, HS_SEND} bcd_hst_t;

   typedef struct packed {
      bcd_hst_t          st;
      logic [NEED_W-1:0] need;
      logic              seq;
      logic              srdy;
      logic              cv;
      logic [WORD_W-1:0] cw;
      logic              cl;
      logic              cx;
      logic              tv;
      logic [TLM_W-1:0]  tw;
      logic              tl;
      logic              trdy;
   } bcd_host_st_t;

   bcd_host_st_t      st_ff;
   bcd_host_st_t      nxt_st;
   logic [WORD_W-1:0] w;

   // One buffer per interval; a sequence load buffer thus travels alone
   always_comb begin
      nxt_st = st_ff;
      w      = src_word;
      if (st_ff.cv && link.cmd_ready) begin
         nxt_st.cv = 1'b0;
      end
      // new buffer only after an interval pulse
      if (link.rti_pulse && st_ff.st == HS_WAIT) begin
         nxt_st.st = HS_SEND;
      end
      if (src_valid && st_ff.srdy) begin
         if (!st_ff.seq && st_ff.need == '0) begin
            if (!src_raw) begin
               w[PAR_HI:PAR_LO] = bcd_par(src_word);
            end
            nxt_st.seq  = (bcd_dest(src_word) == SEQ_LOAD_DEST);
            nxt_st.need = bcd_len(src_word) - 4'h1;
         end else if (!st_ff.seq) begin
            nxt_st.need = st_ff.need - 4'h1;
         end
         nxt_st.cv = 1'b1;
         nxt_st.cw = w;
         nxt_st.cl = src_last;
         nxt_st.cx = src_ext;
         if (src_last) begin
            nxt_st.st   = HS_WAIT;
            nxt_st.need = '0;
            nxt_st.seq  = 1'b0;
         end
      end
      nxt_st.srdy = (nxt_st.st == HS_SEND) && !nxt_st.cv;

      // Telemetry hold register toward the data system
      if (st_ff.tv && snk_ready) begin
         nxt_st.tv = 1'b0;
      end
      if (link.tlm_valid && st_ff.trdy) begin
         nxt_st.tv = 1'b1;
         nxt_st.tw = link.tlm_word;
         nxt_st.tl = link.tlm_last;
      end
      nxt_st.trdy = !nxt_st.tv;
   end

   // State register
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign link.cmd_word  = st_ff.cw;
   assign link.cmd_valid = st_ff.cv;
   assign link.cmd_last  = st_ff.cl;
   assign link.cmd_ext   = st_ff.cx;
   assign link.tlm_ready = st_ff.trdy;
   assign src_ready      = st_ff.srdy;
   assign snk_word       = st_ff.tw;
   assign snk_valid      = st_ff.tv;
   assign snk_last       = st_ff.tl;
endmodule : bcd_bus_end

// *** verification/bcd_link_monitor.sv ***
// Protocol checker for the link between bus end and decoder end
`timescale 1ns/100ps
module bcd_link_monitor #(
   parameter int RTI_CYCLES = 64,
   parameter int BLK        = 8
) (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic [15:0] cmd_word,
   input wire logic        cmd_valid,
   input wire logic        cmd_ready,
   input wire logic        rti_pulse,
   input wire logic [31:0] tlm_word,
   input wire logic        tlm_valid,
   input wire logic        tlm_last,
   input wire logic        tlm_ready
);
   logic       seen_rti_ff;
   logic [3:0] blk_cnt_ff;

   // Interval seen yet, and words taken since the last block end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         seen_rti_ff <= 1'b0;
         blk_cnt_ff  <= 4'h0;
      end else begin
         if (rti_pulse)
            seen_rti_ff <= 1'b1;
         if (tlm_valid && tlm_ready)
            blk_cnt_ff <= tlm_last ? 4'h0 : blk_cnt_ff + 4'h1;
      end
   end

   default clocking mon_cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   chk_rti_period: assert property (rti_pulse |-> ##RTI_CYCLES rti_pulse)
      else $error("interval pulse period wrong");
   chk_rti_single: assert property (rti_pulse |=> !rti_pulse [*8])
      else $error("interval pulse too long");
   chk_cmd_after_rti: assert property (cmd_valid |-> seen_rti_ff)
      else $error("command before first interval");
   chk_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_word))
      else $error("command word not held");
   chk_cmd_gap: assert property (cmd_valid && cmd_ready |=> !cmd_valid)
      else $error("command words too close");
   chk_tlm_hold: assert property (tlm_valid && !tlm_ready |=> tlm_valid && $stable(tlm_word))
      else $error("telemetry word not held");
   chk_blk_end: assert property (tlm_valid && tlm_ready && tlm_last |->
      blk_cnt_ff == 4'h0 || blk_cnt_ff == 4'(BLK - 1))
      else $error("block ended at wrong size");
   chk_blk_len: assert property (tlm_valid && tlm_ready && !tlm_last |->
      blk_cnt_ff < 4'(BLK - 1))
      else $error("block longer than its size");
endmodule : bcd_link_monitor

// *** verification/bus_command_decoder_test.sv ***
// Self-checking bench for the bus end and decoder end pair
`timescale 1ns/100ps
module bus_command_decoder_test;
   import bcd_pkg::*;
   logic        clock, rst_n, src_valid, src_last, src_raw, src_ext, src_ready, ce, dma_active;
   logic        snk_valid, snk_last, snk_ready, ipc_valid, ipc_first, ipc_ready, bpc_write;
   logic        tlm_in_valid, tlm_in_hrs, tlm_in_ready, parity_drop, length_drop;
   logic [15:0] src_word, cmd_byte_count;
   logic [31:0] snk_word, tlm_in_word;
   logic [7:0]  ipc_data;
   logic [1:0]  ipc_proc;
   logic [10:0] ipc_q[$];
   logic [32:0] snk_q[$];
   int          fails, check_count, pd_n, ld_n;

   bcd_link_if link ();
   bcd_bus_end bcd_bus_end_inst (.clock(clock), .rst_n(rst_n), .ce(ce), .link(link),
      .src_word(src_word), .src_valid(src_valid), .src_last(src_last), .src_raw(src_raw),
      .src_ext(src_ext), .src_ready(src_ready), .snk_word(snk_word), .snk_valid(snk_valid),
      .snk_last(snk_last), .snk_ready(snk_ready));
   bcd_decoder_end #(.RTI_CYCLES(64), .BLK(8), .DEPTH(8)) bcd_decoder_end_inst (
      .clock(clock), .rst_n(rst_n), .ce(ce), .link(link), .ipc_data(ipc_data),
      .ipc_valid(ipc_valid), .ipc_first(ipc_first), .ipc_proc(ipc_proc), .ipc_ready(ipc_ready),
      .tlm_in_word(tlm_in_word), .tlm_in_valid(tlm_in_valid), .tlm_in_hrs(tlm_in_hrs),
      .tlm_in_ready(tlm_in_ready), .bpc_write(bpc_write), .dma_active(dma_active),
      .cmd_byte_count(cmd_byte_count), .parity_drop(parity_drop), .length_drop(length_drop));
   bcd_link_monitor #(.RTI_CYCLES(64), .BLK(8)) bcd_link_monitor_inst (.clock(clock),
      .rst_n(rst_n), .cmd_word(link.cmd_word), .cmd_valid(link.cmd_valid),
      .cmd_ready(link.cmd_ready), .rti_pulse(link.rti_pulse), .tlm_word(link.tlm_word),
      .tlm_valid(link.tlm_valid), .tlm_last(link.tlm_last), .tlm_ready(link.tlm_ready));

   // Collect channel bytes, delivered telemetry and drop pulses
   always @(posedge clock) begin
      if (ipc_valid === 1'b1 && ipc_ready)
         ipc_q.push_back({ipc_first, ipc_proc, ipc_data});
      if (snk_valid === 1'b1 && snk_ready)
         snk_q.push_back({snk_last, snk_word});
      if (parity_drop === 1'b1)
         pd_n++;
      if (length_drop === 1'b1)
         ld_n++;
   end

   task automatic chk(input logic [32:0] got, input logic [32:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out;
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   // First word with good parity; l is the length field, one less than words
   function automatic logic [15:0] mk(input logic [3:0] d, input logic [2:0] l,
                                      input logic [6:0] f);
      return {~^{d, l}, ^f, d, l, f};
   endfunction : mk

   // Bounded wait for a ready, sampled at the taking edge
   task automatic handshake(input logic tlm);
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while ((tlm ? tlm_in_ready : src_ready) !== 1'b1 && n < 300);
      if (n >= 300)
         fails++;
   endtask : handshake

   task automatic send(input logic [15:0] w, input logic last, input logic raw,
                       input logic ext);
      @(posedge clock) #1;
      src_word = w;
      src_last = last;
      src_raw = raw;
      src_ext = ext;
      src_valid = 1'b1;
      handshake(1'b0);
      #1 src_valid = 1'b0;
   endtask : send

   task automatic tput(input logic [31:0] w, input logic hrs);
      @(posedge clock) #1;
      tlm_in_word = w;
      tlm_in_hrs = hrs;
      tlm_in_valid = 1'b1;
      handshake(1'b1);
      #1 tlm_in_valid = 1'b0;
   endtask : tput

   // Both bytes of a word, high first, only the high one may flag a start
   task automatic want(input logic [15:0] w, input logic [1:0] p, input logic f);
      repeat (300) if (ipc_q.size() < 2) @(posedge clock);
      chk(ipc_q.pop_front(), {f, p, w[15:8]});
      chk(ipc_q.pop_front(), {1'b0, p, w[7:0]});
   endtask : want

   task automatic wsnk(input logic [32:0] e);
      repeat (300) if (snk_q.size() == 0) @(posedge clock);
      chk(snk_q.pop_front(), e);
   endtask : wsnk

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // Whole run is well under 2000 cycles
   initial begin
      #20000;
      fails++;
      close_out();
   end

   initial begin
      {rst_n, bpc_write, src_valid, src_last, src_raw, src_ext, tlm_in_valid, tlm_in_hrs} = '0;
      src_word = 16'h0000;
      tlm_in_word = 32'h00000000;
      {ce, ipc_ready, snk_ready} = 3'h7;
      repeat (4) @(posedge clock);
      #1 rst_n = 1'b1;
      // One buffer, three commands, one per processor
      send(mk(4'h1, 3'h0, 7'h55), 1'b0, 1'b0, 1'b1);
      send(mk(4'h7, 3'h1, 7'h2A), 1'b0, 1'b0, 1'b1);
      send(16'hBEEF, 1'b0, 1'b0, 1'b1);
      send(mk(4'hC, 3'h0, 7'h7F), 1'b1, 1'b0, 1'b1);
      want(mk(4'h1, 3'h0, 7'h55), 2'h0, 1'b1);
      want(mk(4'h7, 3'h1, 7'h2A), 2'h1, 1'b1);
      want(16'hBEEF, 2'h1, 1'b0);
      want(mk(4'hC, 3'h0, 7'h7F), 2'h2, 1'b1);
      chk(cmd_byte_count, 16'h0008);
      // Loader with reversed parity drops the rest of its buffer
      send(mk(4'h2, 3'h0, 7'h11) ^ 16'hC000, 1'b0, 1'b1, 1'b0);
      send(mk(4'h3, 3'h0, 7'h01), 1'b1, 1'b0, 1'b0);
      {bpc_write, ipc_ready} = 2'h2;
      send(mk(4'h2, 3'h0, 7'h11), 1'b1, 1'b0, 1'b1);
      repeat (20) @(posedge clock);
      chk({ipc_q.size(), dma_active}, 0);
      #1 {bpc_write, ipc_ready} = 2'h1;
      want(mk(4'h2, 3'h0, 7'h11), 2'h0, 1'b1);
      chk(pd_n, 1);
      chk(cmd_byte_count, 16'h000A);
      // Good command, then one that claims more words than remain
      send(mk(4'h5, 3'h0, 7'h33), 1'b0, 1'b0, 1'b1);
      send(mk(4'h3, 3'h2, 7'h01), 1'b0, 1'b0, 1'b1);
      send(16'h1234, 1'b1, 1'b0, 1'b1);
      want(mk(4'h5, 3'h0, 7'h33), 2'h0, 1'b1);
      repeat (40) @(posedge clock);
      chk(ipc_q.size(), 0);
      chk(ld_n, 1);
      // Seven words must not release a block; the eighth does, sink stalled
      for (int i = 0; i < 7; i++)
         tput(32'hA0000000 + i, 1'b0);
      repeat (20) @(posedge clock);
      chk(snk_q.size(), 0);
      snk_ready = 1'b0;
      tput(32'hA0000007, 1'b0);
      repeat (20) @(posedge clock);
      #1 snk_ready = 1'b1;
      for (int i = 0; i < 8; i++)
         wsnk({i == 7, 32'hA0000000 + i});
      tput(32'hCAFE0001, 1'b1);
      wsnk({1'b1, 32'hCAFE0001});
      close_out();
   end
endmodule : bus_command_decoder_test
